//--- logic/uei_pkg.sv
// Package for the UART event interrupt register block
`default_nettype none
package uei_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0]  ENABLE_OFFSET    = 8'h08;
	localparam logic [7:0]  FLAGS_OFFSET     = 8'h0c;
	localparam logic [7:0]  THRESHOLD_OFFSET = 8'h00;
	localparam logic [31:0] ENABLE_RESET     = 32'h0000_0000;
	localparam logic [31:0] FLAGS_RESET      = 32'h0000_0000;
	localparam logic [3:0]  THRESHOLD_RESET  = 4'h0;
	localparam logic [3:0]  THRESHOLD_MIN    = 4'h1;
	localparam logic [3:0]  THRESHOLD_MAX    = 4'h8;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int BIT_FRAMING_ERROR   = 0;
	localparam int BIT_PARITY_ERROR    = 1;
	localparam int BIT_CTS_CHANGE      = 2;
	localparam int BIT_RECEIVE_OVERRUN = 3;
	localparam int BIT_RX_THRESHOLD    = 4;
	localparam int BIT_TX_HALF_EMPTY   = 6;
	localparam int NUM_BITS            = 7;
	localparam logic [6:0] IMPLEMENTED_MASK = 7'h5f;
endpackage
`default_nettype wire

//--- logic/uei_threshold_detect.sv
// Receive FIFO threshold event detector
`default_nettype none
module uei_threshold_detect (
	// Clock and reset
	input  wire logic       core_clk_in,
	input  wire logic       resetn_in,
	// Level and setting
	input  wire logic [3:0] rx_level_in,
	input  wire logic [3:0] threshold_in,
	// Event
	output logic            event_out
);
	logic reached;
	logic reached_q;

	// R13: valid threshold compare
	always_comb begin
		reached = (threshold_in >= uei_pkg::THRESHOLD_MIN) && (threshold_in <= uei_pkg::THRESHOLD_MAX)
		          && (rx_level_in >= threshold_in);
	end

	// Pulse only on the rising crossing, so a steady level does not re-arm a cleared flag
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			reached_q <= 1'b0;
			event_out <= 1'b0;
		end else begin
			reached_q <= reached;
			event_out <= reached & ~reached_q;
		end
	end
endmodule
`default_nettype wire

//--- logic/uei_event_regs.sv
// UART event interrupt enable and flag registers
// Behaviour
// R1: Enable bit 6 for transmit half-empty event, read/write, resets 0.
// R2: Enable bit 4 for receive threshold event, read/write, resets 0.
// R3: Enable bit 3 for receive overrun event, read/write, resets 0.
// R4: Enable bit 2 for clear-to-send change event, read/write, resets 0.
// R5: Enable bit 1 for receive parity error event, read/write, resets 0.
// R6: Enable bit 0 for receive framing error event, read/write, resets 0.
// R7: Flag bit 6 transmit half-empty, resets 0, write one clears.
// R8: Flag bit 4 receive threshold, resets 0, write one clears.
// R9: Flag bit 3 receive overrun, resets 0, write one clears.
// R10: Flag bit 2 clear-to-send change, resets 0, write one clears.
// R11: Flag bit 1 parity error, resets 0, write one clears.
// R12: Flag bit 0 framing error, resets 0, write one clears.
// R13: Threshold event compares fill level to 4-bit setting, valid 1 to 8.
// R14: Flags set regardless of enable; interrupt while flag and enable both set.
// R15: Bits 31 to 7 and bit 5 read zero, writes ignored.
//
// Decided for this implementation: the strobed register port.
`default_nettype none
module uei_event_regs (
	// Clock and reset
	input  wire logic        core_clk_in,
	input  wire logic        resetn_in,
	// Register port
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [31:0] reg_wdata_in,
	input  wire logic        reg_write_in,
	input  wire logic        reg_read_in,
	output logic [31:0]      reg_rdata_out,
	// Event pulses and receive FIFO fill level
	input  wire logic        transmit_half_empty_in,
	input  wire logic        receive_overrun_in,
	input  wire logic        clear_to_send_change_in,
	input  wire logic        parity_error_in,
	input  wire logic        framing_error_in,
	input  wire logic [3:0]  rx_level_in,
	// Interrupt
	output logic             irq_out
);
	// ****************************************
	// State
	// ****************************************
	logic [6:0] uart_event_enable;
	logic [6:0] uart_event_flags;
	logic [3:0] rx_threshold;
	logic       threshold_event;
	logic [6:0] events;
	logic       wr_enable;
	logic       wr_flags;
	logic       wr_threshold;

	assign wr_enable    = reg_write_in && (reg_addr_in == uei_pkg::ENABLE_OFFSET);
	assign wr_flags     = reg_write_in && (reg_addr_in == uei_pkg::FLAGS_OFFSET);
	assign wr_threshold = reg_write_in && (reg_addr_in == uei_pkg::THRESHOLD_OFFSET);

	// ****************************************
	// Threshold detector
	// ****************************************
	uei_threshold_detect u_threshold (
		.core_clk_in  (core_clk_in),
		.resetn_in    (resetn_in),
		.rx_level_in  (rx_level_in),
		.threshold_in (rx_threshold),
		.event_out    (threshold_event)
	);

	// R13: threshold setting register
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			rx_threshold <= uei_pkg::THRESHOLD_RESET;
		end else if (wr_threshold) begin
			rx_threshold <= reg_wdata_in[3:0];
		end
	end

	always_comb begin
		events = 7'h00;
		events[uei_pkg::BIT_TX_HALF_EMPTY]   = transmit_half_empty_in;
		events[uei_pkg::BIT_RX_THRESHOLD]    = threshold_event;
		events[uei_pkg::BIT_RECEIVE_OVERRUN] = receive_overrun_in;
		events[uei_pkg::BIT_CTS_CHANGE]      = clear_to_send_change_in;
		events[uei_pkg::BIT_PARITY_ERROR]    = parity_error_in;
		events[uei_pkg::BIT_FRAMING_ERROR]   = framing_error_in;
	end

	// ****************************************
	// Enable register
	// ****************************************
	// R1 R2 R3 R4 R5 R6: read/write enables
	// R15: reserved bits masked
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			uart_event_enable <= uei_pkg::ENABLE_RESET[6:0];
		end else if (wr_enable) begin
			uart_event_enable <= reg_wdata_in[6:0] & uei_pkg::IMPLEMENTED_MASK;
		end
	end

	// ****************************************
	// Flag register
	// ****************************************
	// One loop per flag; an event in the clearing cycle wins over the clear
	genvar i;
	generate
		for (i = 0; i < uei_pkg::NUM_BITS; i++) begin : g_flag
			if (uei_pkg::IMPLEMENTED_MASK[i]) begin : g_impl
				// R7 R8 R9 R10 R11 R12: sticky write-one-clear
				// R14: set ignores enable
				always_ff @(posedge core_clk_in) begin
					if (!resetn_in) begin
						uart_event_flags[i] <= uei_pkg::FLAGS_RESET[i];
					end else if (events[i]) begin
						uart_event_flags[i] <= 1'b1;
					end else if (wr_flags && reg_wdata_in[i]) begin
						uart_event_flags[i] <= 1'b0;
					end
				end
			end else begin : g_resv
				// R15: reserved flag stays zero
				// Kept as a flop so every bit of the vector has the same kind of driver
				always_ff @(posedge core_clk_in) begin
					uart_event_flags[i] <= 1'b0;
				end
			end
		end
	endgenerate

	// ****************************************
	// Interrupt output
	// ****************************************
	// Uses next flag values so irq lines up with the flag it reflects
	logic [6:0] next_flags;
	always_comb begin
		next_flags = (uart_event_flags & ~({7{wr_flags}} & reg_wdata_in[6:0])) | events;
		next_flags = next_flags & uei_pkg::IMPLEMENTED_MASK;
	end

	// R14: flag and enable both set
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(next_flags & (wr_enable ? (reg_wdata_in[6:0] & uei_pkg::IMPLEMENTED_MASK)
			                                     : uart_event_enable));
		end
	end

	// ****************************************
	// Read port
	// ****************************************
	// R15: upper bits read as zero
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			reg_rdata_out <= 32'h0000_0000;
		end else if (reg_read_in) begin
			case (reg_addr_in)
				uei_pkg::ENABLE_OFFSET: begin
					reg_rdata_out <= {25'h0, uart_event_enable};
				end
				uei_pkg::FLAGS_OFFSET: begin
					reg_rdata_out <= {25'h0, uart_event_flags};
				end
				uei_pkg::THRESHOLD_OFFSET: begin
					reg_rdata_out <= {28'h0, rx_threshold};
				end
				default: begin
					reg_rdata_out <= 32'h0000_0000;
				end
			endcase
		end else begin
			reg_rdata_out <= 32'h0000_0000;
		end
	end
endmodule
`default_nettype wire

//--- dv/uei_event_regs_checker.sv
// Port checker for the UART event register block
`default_nettype none
module uei_event_regs_checker (
	// Clock, reset and register port
	input wire logic        core_clk_in,
	input wire logic        resetn_in,
	input wire logic [7:0]  reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic        reg_write_in,
	input wire logic        reg_read_in,
	input wire logic [31:0] reg_rdata_out,
	// Event and interrupt
	input wire logic        framing_error_in,
	input wire logic        irq_out
);
	// ****************************************
	// Port relations
	// ****************************************
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);
	sequence rd_flags;
		reg_read_in && reg_addr_in == 8'h0c;
	endsequence
	sequence clr_frame;
		reg_write_in && reg_addr_in == 8'h0c && reg_wdata_in[0] && !framing_error_in;
	endsequence
	property p_enable_rw;
		logic [31:0] d;
		(reg_write_in && reg_addr_in == 8'h08, d = reg_wdata_in) ##1 (reg_read_in && reg_addr_in == 8'h08)
			|=> reg_rdata_out == (d & 32'h5f);
	endproperty
	a_rdata_idle: assert property (!reg_read_in |=> reg_rdata_out == 32'h0)
		else $error("read data not zero outside read");
	a_reserved_zero: assert property (reg_read_in |=> reg_rdata_out[31:7] == 25'h0 && !reg_rdata_out[5])
		else $error("reserved bits read nonzero");
	a_unmapped_zero: assert property (reg_read_in && !(reg_addr_in inside {8'h00, 8'h08, 8'h0c})
		|=> reg_rdata_out == 32'h0) else $error("unmapped read nonzero");
	a_frame_sets: assert property (framing_error_in ##1 rd_flags |=> reg_rdata_out[0])
		else $error("framing flag not set");
	a_frame_clears: assert property (clr_frame ##1 rd_flags |=> !reg_rdata_out[0])
		else $error("framing flag not cleared");
	a_enable_rw: assert property (p_enable_rw)
		else $error("enable readback wrong");
	a_irq_fall: assert property ($fell(irq_out) |-> $past(reg_write_in))
		else $error("interrupt dropped without write");
	a_reset_quiet: assert property (disable iff (1'b0) !resetn_in |=> !irq_out && reg_rdata_out == 32'h0)
		else $error("outputs not quiet in reset");
endmodule
bind uei_event_regs uei_event_regs_checker u_chk (.core_clk_in, .resetn_in, .reg_addr_in, .reg_wdata_in,
	.reg_write_in, .reg_read_in, .reg_rdata_out, .framing_error_in, .irq_out);
`default_nettype wire

//--- dv/tb_uei_event_regs.sv
// Testbench for the UART event register block
`default_nettype none
module tb_uei_event_regs;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, resetn, write, read, irq;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata;
	logic [6:0]  ev;
	logic [3:0]  lvl;
	int          errors, comparisons, cycles;
	int          bits[5] = '{0, 1, 2, 3, 6};
	int          thr[4] = '{1, 8, 0, 9};
	uei_event_regs u_uei_event_regs (.core_clk_in(clk), .resetn_in(resetn), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_write_in(write), .reg_read_in(read), .reg_rdata_out(rdata),
		.transmit_half_empty_in(ev[6]), .receive_overrun_in(ev[3]), .clear_to_send_change_in(ev[2]),
		.parity_error_in(ev[1]), .framing_error_in(ev[0]), .rx_level_in(lvl), .irq_out(irq));
	// ****************************************
	// Bus tasks and checks
	// ****************************************
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk) begin addr <= a; wdata <= d; write <= 1'b1; end
		@(posedge clk) write <= 1'b0;
		#1;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk) begin addr <= a; read <= 1'b1; end
		@(posedge clk) read <= 1'b0;
		#1 chk(rdata, exp);
	endtask
	task wrrd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
		wr(a, d);
		rd(a, exp);
	endtask
	// Event pulse with the flag read in the very next cycle
	task evrd(input logic [6:0] m, input logic [31:0] exp);
		@(posedge clk) ev <= m;
		@(posedge clk) begin ev <= 7'h0; addr <= 8'h0c; read <= 1'b1; end
		@(posedge clk) read <= 1'b0;
		#1 chk(rdata, exp);
	endtask
	task wrap_up;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Generous ceiling: the sequence needs about 150 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			wrap_up();
		end
	end
	initial begin
		{resetn, write, read, addr, wdata, ev, lvl} <= '0;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		rd(8'h08, 32'h0);
		rd(8'h0c, 32'h0);
		chk({31'h0, irq}, 32'h0);
		$display("test reset done");
		wrrd(8'h08, 32'hffffffff, 32'h5f);
		wrrd(8'h08, 32'h0, 32'h0);
		$display("test enable done");
		foreach (bits[k]) begin
			evrd(7'h1 << bits[k], 32'h1 << bits[k]);
			chk({31'h0, irq}, 32'h0);
			wrrd(8'h0c, ~(32'h1 << bits[k]), 32'h1 << bits[k]);
			wrrd(8'h0c, 32'h1 << bits[k], 32'h0);
		end
		$display("test flags done");
		wr(8'h08, 32'h1);
		evrd(7'h1, 32'h1);
		chk({31'h0, irq}, 32'h1);
		wr(8'h08, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(8'h08, 32'h1);
		chk({31'h0, irq}, 32'h1);
		wr(8'h0c, 32'h1);
		chk({31'h0, irq}, 32'h0);
		$display("test irq done");
		foreach (thr[k]) begin
			wr(8'h00, thr[k]);
			@(posedge clk) lvl <= (thr[k] == 9) ? 4'hf : 4'h8;
			repeat (3) @(posedge clk);
			rd(8'h0c, (thr[k] inside {[1:8]}) ? 32'h10 : 32'h0);
			wr(8'h0c, 32'h10);
			@(posedge clk) lvl <= 4'h0;
			repeat (3) @(posedge clk);
		end
		$display("test threshold done");
		wrrd(8'h04, 32'hffffffff, 32'h0);
		rd(8'h0c, 32'h0);
		rd(8'h08, 32'h1);
		$display("test unmapped done");
		wrap_up();
	end
endmodule
`default_nettype wire
